/* File: gpio_pinmux_pkg.sv */
// Purpose: Shared constants and carrier types for the B/C/D/E pin mux.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Index 0..3 of every per-port array stands for ports B..E.
package gpio_pinmux_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_B_SEL = 32'h5600_0010;
    localparam logic [31:0] ADDR_B_DAT = 32'h5600_0014;
    localparam logic [31:0] ADDR_B_PUD = 32'h5600_0018;
    localparam logic [31:0] ADDR_B_RSV = 32'h5600_001c;
    localparam logic [31:0] ADDR_C_SEL = 32'h5600_0020;
    localparam logic [31:0] ADDR_C_DAT = 32'h5600_0024;
    localparam logic [31:0] ADDR_C_PUD = 32'h5600_0028;
    localparam logic [31:0] ADDR_C_RSV = 32'h5600_002c;
    localparam logic [31:0] ADDR_D_SEL = 32'h5600_0030;
    localparam logic [31:0] ADDR_D_DAT = 32'h5600_0034;
    localparam logic [31:0] ADDR_D_PUD = 32'h5600_0038;
    localparam logic [31:0] ADDR_D_RSV = 32'h5600_003c;
    localparam logic [31:0] ADDR_E_SEL = 32'h5600_0040;
    localparam logic [31:0] ADDR_E_DAT = 32'h5600_0044;
    localparam logic [31:0] ADDR_E_PUD = 32'h5600_0048;
    localparam logic [31:0] ADDR_E_RSV = 32'h5600_004c;

    // Register kind inside a port's four words
    localparam logic [1:0] KIND_SEL = 2'h0;
    localparam logic [1:0] KIND_DAT = 2'h1;
    localparam logic [1:0] KIND_PUD = 2'h2;
    localparam logic [1:0] KIND_RSV = 2'h3;

    localparam logic [1:0] PORT_B = 2'h0;
    localparam logic [1:0] PORT_C = 2'h1;
    localparam logic [1:0] PORT_D = 2'h2;
    localparam logic [1:0] PORT_E = 2'h3;

    // ------------------------------------------------------------------
    // Field codes, masks, resets
    // ------------------------------------------------------------------
    localparam logic [1:0] CODE_INPUT  = 2'h0;
    localparam logic [1:0] CODE_OUTPUT = 2'h1;
    localparam logic [1:0] CODE_ALT_A  = 2'h2;
    localparam logic [1:0] CODE_ALT_B  = 2'h3;

    localparam logic [3:0][31:0] SEL_MASK = {
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h003f_ffff};
    localparam logic [3:0][15:0] PIN_MASK = {
        16'hffff, 16'hffff, 16'hffff, 16'h07ff};
    localparam logic [3:0][31:0] SEL_RESET = '0;
    localparam logic [3:0][15:0] DAT_RESET = '0;
    localparam logic [3:0][15:0] PUD_RESET = {
        16'h0000, 16'hf000, 16'h0000, 16'h0000};

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
        logic [15:0] pullup_en;
    } pad_t;

endpackage : gpio_pinmux_pkg

/* File: gpio_ports_b_to_e_pinmux.sv */
// Purpose: Pin function select, data and pull-up control, ports B to E.
// Assumes: One clock; pad inputs are asynchronous and are synchronised.
// Notes:   Port E carries plain input/output only; its alternates live
//          elsewhere, so codes 10 and 11 leave an E pin as an input.
`timescale 1ns/1ns
`default_nettype none

module gpio_ports_b_to_e_pinmux (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire gpio_pinmux_pkg::apb_req_t apb_req,
    output var  gpio_pinmux_pkg::apb_rsp_t apb_rsp,

    input  wire logic [3:0][15:0]          pad_in,

    output var  gpio_pinmux_pkg::pad_t     pad_b,
    output var  gpio_pinmux_pkg::pad_t     pad_c,
    output var  gpio_pinmux_pkg::pad_t     pad_d,
    output var  gpio_pinmux_pkg::pad_t     pad_e,

    output logic                           ext_dma_request_0_n,
    input  wire logic                      ext_dma_ack_0_n,
    output logic                           ext_dma_request_1_n,
    input  wire logic                      ext_dma_ack_1_n,
    output logic                           ext_bus_request_n,
    input  wire logic                      ext_bus_grant_n,

    output logic                           timer_ext_clock_0,
    input  wire logic [3:0]                timer_output,

    input  wire logic [23:0]               lcd_pixel_data,
    input  wire logic                      lcd_panel_reverse_inv,
    input  wire logic                      lcd_panel_reverse,
    input  wire logic                      lcd_panel_output_enable,
    input  wire logic                      lcd_ac_bias,
    output logic                           audio_serial_data_in,
    input  wire logic                      lcd_frame_sync,
    input  wire logic                      lcd_line_sync,
    input  wire logic                      lcd_pixel_clock,
    input  wire logic                      lcd_line_end,

    output logic                           spi_slave_select_0_n,
    output logic                           spi_slave_select_1_n,

    input  wire logic                      spi_ch1_clock_out,
    input  wire logic                      spi_ch1_clock_oe,
    output logic                           spi_ch1_clock_in,
    input  wire logic                      spi_ch1_master_out_out,
    input  wire logic                      spi_ch1_master_out_oe,
    output logic                           spi_ch1_master_out_in,
    input  wire logic                      spi_ch1_master_in_out,
    input  wire logic                      spi_ch1_master_in_oe,
    output logic                           spi_ch1_master_in_in
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Software-visible registers
        logic [3:0][31:0] sel;
        logic [3:0][15:0] dat;
        logic [3:0][15:0] pud;

        // Two-stage pad synchroniser
        logic [3:0][15:0] sync1;
        logic [3:0][15:0] sync2;

        // Bus answer, captured in setup
        logic [31:0]      prdata;
        logic             slverr;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Returns {hit, port, kind}; anything outside the sixteen words misses
    function automatic logic [4:0] decode(input logic [31:0] a);
        unique case (a)
            gpio_pinmux_pkg::ADDR_B_SEL: decode = 5'h10;
            gpio_pinmux_pkg::ADDR_B_DAT: decode = 5'h11;
            gpio_pinmux_pkg::ADDR_B_PUD: decode = 5'h12;
            gpio_pinmux_pkg::ADDR_B_RSV: decode = 5'h13;

            gpio_pinmux_pkg::ADDR_C_SEL: decode = 5'h14;
            gpio_pinmux_pkg::ADDR_C_DAT: decode = 5'h15;
            gpio_pinmux_pkg::ADDR_C_PUD: decode = 5'h16;
            gpio_pinmux_pkg::ADDR_C_RSV: decode = 5'h17;

            gpio_pinmux_pkg::ADDR_D_SEL: decode = 5'h18;
            gpio_pinmux_pkg::ADDR_D_DAT: decode = 5'h19;
            gpio_pinmux_pkg::ADDR_D_PUD: decode = 5'h1a;
            gpio_pinmux_pkg::ADDR_D_RSV: decode = 5'h1b;

            gpio_pinmux_pkg::ADDR_E_SEL: decode = 5'h1c;
            gpio_pinmux_pkg::ADDR_E_DAT: decode = 5'h1d;
            gpio_pinmux_pkg::ADDR_E_PUD: decode = 5'h1e;
            gpio_pinmux_pkg::ADDR_E_RSV: decode = 5'h1f;
            default:                     decode = 5'h00;
        endcase
    endfunction : decode

    function automatic logic [1:0] code_of(input logic [31:0] sel,
                                           input int          pin);
        code_of = sel[2*pin +: 2];
    endfunction : code_of

    // Output pins read their latch; all others read the synchronised pad.
    // An alternate pin therefore reads the pad level, which software
    // must treat as meaningless.
    function automatic logic [15:0] read_dat(input logic [31:0] sel,
                                             input logic [15:0] dat,
                                             input logic [15:0] pin);
        read_dat = pin;

        for (int i = 0; i < 16; i++) begin
            if (code_of(sel, i) == gpio_pinmux_pkg::CODE_OUTPUT) begin
                read_dat[i] = dat[i];
            end
        end
    endfunction : read_dat

    // ------------------------------------------------------------------
    // Next state and APB slave
    // ------------------------------------------------------------------
    logic [4:0] dec;
    logic [1:0] dport;
    logic [1:0] dkind;

    always_comb begin
        state_d       = state_q;

        // Only the second stage is read by any logic
        state_d.sync1 = pad_in;
        state_d.sync2 = state_q.sync1;

        dec   = decode(apb_req.paddr);
        dport = dec[3:2];
        dkind = dec[1:0];

        // Read data is captured in setup so prdata comes from a flop
        if (apb_req.psel && !apb_req.penable) begin
            // Unmapped words answer with an error
            state_d.slverr = !dec[4];
            state_d.prdata = '0;
            if (dec[4]) begin
                unique case (dkind)
                    gpio_pinmux_pkg::KIND_SEL:
                        state_d.prdata = state_q.sel[dport];
                    gpio_pinmux_pkg::KIND_DAT:
                        state_d.prdata = {16'h0000,
                            read_dat(state_q.sel[dport],
                                     state_q.dat[dport],
                                     state_q.sync2[dport])
                            & gpio_pinmux_pkg::PIN_MASK[dport]};
                    gpio_pinmux_pkg::KIND_PUD:
                        state_d.prdata = {16'h0000, state_q.pud[dport]};
                    gpio_pinmux_pkg::KIND_RSV:
                        state_d.prdata = '0;
                endcase
            end
        end

        // Writes land only in the access cycle
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && dec[4]) begin
            unique case (dkind)
                gpio_pinmux_pkg::KIND_SEL:
                    state_d.sel[dport] = apb_req.pwdata
                        & gpio_pinmux_pkg::SEL_MASK[dport];
                gpio_pinmux_pkg::KIND_DAT:
                    state_d.dat[dport] = apb_req.pwdata[15:0]
                        & gpio_pinmux_pkg::PIN_MASK[dport];
                gpio_pinmux_pkg::KIND_PUD:
                    state_d.pud[dport] = apb_req.pwdata[15:0]
                        & gpio_pinmux_pkg::PIN_MASK[dport];
                gpio_pinmux_pkg::KIND_RSV: ;
            endcase
        end
    end

    // Data latches take a plain zero at reset; software may not count on it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q.sel    <= gpio_pinmux_pkg::SEL_RESET;
            state_q.dat    <= gpio_pinmux_pkg::DAT_RESET;
            state_q.pud    <= gpio_pinmux_pkg::PUD_RESET;
            state_q.sync1  <= '0;
            state_q.sync2  <= '0;

            state_q.prdata <= '0;
            state_q.slverr <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // Zero wait states: every access completes in its first access cycle
    always_comb begin
        apb_rsp.prdata  = state_q.prdata;
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = state_q.slverr;
    end

    // ------------------------------------------------------------------
    // Alternate function tables
    // ------------------------------------------------------------------
    logic [3:0][15:0] alt_a_out;
    logic [3:0][15:0] alt_a_oe;
    logic [3:0][15:0] alt_b_out;
    logic [3:0][15:0] alt_b_oe;

    always_comb begin
        alt_a_out = '0;
        alt_a_oe  = '0;
        alt_b_out = '0;
        alt_b_oe  = '0;

        // Port B: input-only alternates keep the driver off
        alt_a_out[0][9]   = ext_dma_ack_0_n;
        alt_a_out[0][7]   = ext_dma_ack_1_n;
        alt_a_out[0][5]   = ext_bus_grant_n;
        alt_a_out[0][3:0] = timer_output;
        alt_a_oe[0]       = 16'h02af;

        // Port C
        alt_a_out[1][15:8] = lcd_pixel_data[7:0];
        alt_a_out[1][7]    = lcd_panel_reverse_inv;
        alt_a_out[1][6]    = lcd_panel_reverse;
        alt_a_out[1][5]    = lcd_panel_output_enable;
        alt_a_out[1][4]    = lcd_ac_bias;
        alt_a_out[1][3]    = lcd_frame_sync;
        alt_a_out[1][2]    = lcd_line_sync;
        alt_a_out[1][1]    = lcd_pixel_clock;
        alt_a_out[1][0]    = lcd_line_end;
        alt_a_oe[1]        = 16'hffff;

        // Port D
        alt_a_out[2]  = lcd_pixel_data[23:8];
        alt_a_oe[2]   = 16'hffff;

        alt_b_out[2][10] = spi_ch1_clock_out;
        alt_b_oe[2][10]  = spi_ch1_clock_oe;
        alt_b_out[2][9]  = spi_ch1_master_out_out;
        alt_b_oe[2][9]   = spi_ch1_master_out_oe;
        alt_b_out[2][8]  = spi_ch1_master_in_out;
        alt_b_oe[2][8]   = spi_ch1_master_in_oe;
    end

    // ------------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------------
    wire [3:0][15:0] drv_out;
    wire [3:0][15:0] drv_oe;

    genvar gp;
    genvar gi;

    generate
        for (gp = 0; gp < 4; gp++) begin : g_port
            for (gi = 0; gi < 16; gi++) begin : g_pin
                // Pins past the port width stay undriven
                logic [1:0] code;
                logic       used;
                assign code = code_of(state_q.sel[gp], gi);
                assign used = gpio_pinmux_pkg::PIN_MASK[gp][gi];
                // Code 11 without a listed function has no driver
                assign drv_out[gp][gi] = !used ? 1'b0 :
                    (code == gpio_pinmux_pkg::CODE_OUTPUT) ?
                        state_q.dat[gp][gi] :
                    (code == gpio_pinmux_pkg::CODE_ALT_A) ?
                        alt_a_out[gp][gi] :
                    (code == gpio_pinmux_pkg::CODE_ALT_B) ?
                        alt_b_out[gp][gi] : 1'b0;
                assign drv_oe[gp][gi] = used &&
                    ((code == gpio_pinmux_pkg::CODE_OUTPUT) ||
                     (code == gpio_pinmux_pkg::CODE_ALT_A
                         && alt_a_oe[gp][gi]) ||
                     (code == gpio_pinmux_pkg::CODE_ALT_B
                         && alt_b_oe[gp][gi]));
            end
        end
    endgenerate

    // Pull-ups follow only their own bit, whatever the function
    always_comb begin
        // Port B bits past pin 10 never pull up
        pad_b.out       = drv_out[0];
        pad_b.oe        = drv_oe[0];
        pad_b.pullup_en = ~state_q.pud[0]
                        & gpio_pinmux_pkg::PIN_MASK[0];

        pad_c.out       = drv_out[1];
        pad_c.oe        = drv_oe[1];
        pad_c.pullup_en = ~state_q.pud[1];

        pad_d.out       = drv_out[2];
        pad_d.oe        = drv_oe[2];
        pad_d.pullup_en = ~state_q.pud[2];

        pad_e.out       = drv_out[3];
        pad_e.oe        = drv_oe[3];
        pad_e.pullup_en = ~state_q.pud[3];
    end

    // ------------------------------------------------------------------
    // Inputs routed to peripherals
    // ------------------------------------------------------------------
    // Deselected inputs sit at their idle level so peripherals never see
    // a stray request from a pin that serves another purpose.
    always_comb begin
        // Port B: DMA, bus and timer inputs
        ext_dma_request_0_n = (code_of(state_q.sel[0], 10)
            == gpio_pinmux_pkg::CODE_ALT_A) ? state_q.sync2[0][10]
            : 1'b1;

        ext_dma_request_1_n = (code_of(state_q.sel[0], 8)
            == gpio_pinmux_pkg::CODE_ALT_A) ? state_q.sync2[0][8]
            : 1'b1;

        ext_bus_request_n = (code_of(state_q.sel[0], 6)
            == gpio_pinmux_pkg::CODE_ALT_A) ? state_q.sync2[0][6]
            : 1'b1;

        timer_ext_clock_0 = (code_of(state_q.sel[0], 4)
            == gpio_pinmux_pkg::CODE_ALT_A) && state_q.sync2[0][4];

        // Port C: audio data in
        audio_serial_data_in = (code_of(state_q.sel[1], 4)
            == gpio_pinmux_pkg::CODE_ALT_B) && state_q.sync2[1][4];

        // Port D: SPI selects and channel 1
        spi_slave_select_0_n = (code_of(state_q.sel[2], 15)
            == gpio_pinmux_pkg::CODE_ALT_B) ? state_q.sync2[2][15]
            : 1'b1;

        spi_slave_select_1_n = (code_of(state_q.sel[2], 14)
            == gpio_pinmux_pkg::CODE_ALT_B) ? state_q.sync2[2][14]
            : 1'b1;

        spi_ch1_clock_in = (code_of(state_q.sel[2], 10)
            == gpio_pinmux_pkg::CODE_ALT_B) && state_q.sync2[2][10];

        spi_ch1_master_out_in = (code_of(state_q.sel[2], 9)
            == gpio_pinmux_pkg::CODE_ALT_B) && state_q.sync2[2][9];

        spi_ch1_master_in_in = (code_of(state_q.sel[2], 8)
            == gpio_pinmux_pkg::CODE_ALT_B) && state_q.sync2[2][8];
    end

endmodule : gpio_ports_b_to_e_pinmux

`default_nettype wire

/* File: gpio_pinmux_props.sv */
// Purpose: Concurrent checks on the pin mux top ports.
// Assumes: Zero wait state APB; pad outputs follow registers at once.
// Notes:   Write effects are judged one cycle after the access edge.
`timescale 1ns/1ns
`default_nettype none
module gpio_pinmux_props (
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire gpio_pinmux_pkg::apb_req_t apb_req,
    input wire gpio_pinmux_pkg::apb_rsp_t apb_rsp,
    input wire gpio_pinmux_pkg::pad_t     pad_b,
    input wire gpio_pinmux_pkg::pad_t     pad_c,
    input wire gpio_pinmux_pkg::pad_t     pad_d,
    input wire logic                      ext_bus_grant_n,
    input wire logic [3:0]                timer_output
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic       acc;
    logic [7:0] wa;
    logic [7:0] ra;
    assign acc = apb_req.psel && apb_req.penable
                 && apb_req.paddr[31:8] == 24'h56_0000;
    assign wa = (acc && apb_req.pwrite) ? apb_req.paddr[7:0] : 8'h00;
    assign ra = (acc && !apb_req.pwrite) ? apb_req.paddr[7:0] : 8'h00;
    property p_rsv; ra[3:0] == 4'hc && ra[7:4] inside {[4'h1:4'h4]}
        |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read");
    property p_rst_oe; $rose(rst_n) |-> (pad_b.oe | pad_c.oe | pad_d.oe)
        == 16'h0000; endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("oe after reset");
    property p_rst_pu; $rose(rst_n) |-> pad_d.pullup_en == 16'h0fff
        && pad_b.pullup_en == 16'h07ff; endproperty
    a_rst_pu: assert property (p_rst_pu) else $error("pull-up reset");
    property p_pud; wa == 8'h38 |=> pad_d.pullup_en
        == ~$past(apb_req.pwdata[15:0]); endproperty
    a_pud: assert property (p_pud) else $error("pull-up control");
    property p_timer; wa == 8'h10 && apb_req.pwdata[1:0] == 2'h2 |=>
        pad_b.oe[0] && pad_b.out[0] == timer_output[0]; endproperty
    a_timer: assert property (p_timer) else $error("timer pin");
    property p_grant; wa == 8'h10 && apb_req.pwdata[11:10] == 2'h2 |=>
        pad_b.oe[5] && pad_b.out[5] == ext_bus_grant_n; endproperty
    a_grant: assert property (p_grant) else $error("grant pin");
    property p_nss; wa == 8'h30 && apb_req.pwdata[31:30] == 2'h3 |=>
        !pad_d.oe[15]; endproperty
    a_nss: assert property (p_nss) else $error("select pin driven");
    property p_bias; wa == 8'h20 |=> pad_c.oe[4]
        == ^$past(apb_req.pwdata[9:8]); endproperty
    a_bias: assert property (p_bias) else $error("bias pin");
endmodule : gpio_pinmux_props
bind gpio_ports_b_to_e_pinmux gpio_pinmux_props i_props (
    .core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pad_b(pad_b), .pad_c(pad_c), .pad_d(pad_d),
    .ext_bus_grant_n(ext_bus_grant_n), .timer_output(timer_output));
`default_nettype wire

/* File: gpio_board_model.sv */
// Purpose: Board side of the pads: resolves each pin level.
// Assumes: The board drives every pin the device leaves undriven.
// Notes:   No contention model; a driven pin shows the device value.
`timescale 1ns/1ns
`default_nettype none
module gpio_board_model (
    input  wire gpio_pinmux_pkg::pad_t pads [4],
    input  wire logic [3:0][15:0]      drive,
    output var  logic [3:0][15:0]      pad_in
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad_in[i] = (pads[i].oe & pads[i].out) | (~pads[i].oe & drive[i]);
        end
    end
endmodule : gpio_board_model
`default_nettype wire

/* File: gpio_ports_b_to_e_pinmux_tb.sv */
// Purpose: Self-checking bench for the ports B to E pin mux.
// Assumes: Zero wait APB; pads resolved by the board model.
// Notes:   Random data from a fixed seed; every port walked in turn.
`timescale 1ns/1ns
`default_nettype none
module gpio_ports_b_to_e_pinmux_tb;
    localparam logic [31:0] BASE = gpio_pinmux_pkg::ADDR_B_SEL;
    logic                      core_clk;
    logic                      rst_n;
    gpio_pinmux_pkg::apb_req_t req;
    gpio_pinmux_pkg::apb_rsp_t rsp;
    gpio_pinmux_pkg::pad_t     pads [4];
    logic [3:0][15:0]          pin;
    logic [3:0][15:0]          drv;
    logic [44:0]               g;
    logic [9:0]                q;
    logic [31:0]               rd, d, a;
    logic [15:0]               m, e;
    logic                      err;
    int                        n_mismatch, checks, seed;
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    gpio_board_model i_board (.pads(pads), .drive(drv), .pad_in(pin));
    gpio_ports_b_to_e_pinmux i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .pad_in(pin), .pad_b(pads[0]), .pad_c(pads[1]), .pad_d(pads[2]),
        .pad_e(pads[3]), .ext_dma_request_0_n(q[0]), .ext_dma_ack_0_n(g[36]),
        .ext_dma_request_1_n(q[1]), .ext_dma_ack_1_n(g[37]),
        .ext_bus_request_n(q[2]), .ext_bus_grant_n(g[38]),
        .timer_ext_clock_0(q[3]), .timer_output(g[3:0]),
        .lcd_pixel_data(g[27:4]), .lcd_panel_reverse_inv(g[35]),
        .lcd_panel_reverse(g[34]), .lcd_panel_output_enable(g[33]),
        .lcd_ac_bias(g[32]), .audio_serial_data_in(q[4]),
        .lcd_frame_sync(g[31]), .lcd_line_sync(g[30]),
        .lcd_pixel_clock(g[29]), .lcd_line_end(g[28]),
        .spi_slave_select_0_n(q[5]), .spi_slave_select_1_n(q[6]),
        .spi_ch1_clock_out(g[44]), .spi_ch1_clock_oe(g[43]),
        .spi_ch1_clock_in(q[7]), .spi_ch1_master_out_out(g[42]),
        .spi_ch1_master_out_oe(g[41]), .spi_ch1_master_out_in(q[8]),
        .spi_ch1_master_in_out(g[40]), .spi_ch1_master_in_oe(g[39]),
        .spi_ch1_master_in_in(q[9]));
    function automatic logic [15:0] lvl(input logic [15:0] oe, o, x);
        return (oe & o) | (~oe & x);
    endfunction : lvl
    task automatic wrap_up;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Holds the request until pready is seen high at an edge
    task automatic apb(input logic w, input logic [31:0] ad, wd);
        int k;
        @(posedge core_clk);
        req <= '{ad, w, wd, 1'b1, 1'b0};
        @(posedge core_clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        if (rsp.pready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    // Three edges cover the two-flop pad synchroniser
    task automatic rnd;
        @(posedge core_clk);
        g <= 45'({$random(seed), $random(seed)});
        drv <= {$random(seed), $random(seed)};
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask : rnd
    initial begin
        seed = 83001;
        n_mismatch = 0;
        checks = 0;
        rst_n = 1'b0;
        req = '0;
        g = '0;
        drv = '0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            a = BASE + 32'(p * 16);
            m = gpio_pinmux_pkg::PIN_MASK[p];
            apb(1'b0, a, 32'h0);
            chk("sel reset", rd, 32'h0);
            apb(1'b0, a + 32'h8, 32'h0);
            chk("pud reset", rd, 32'(gpio_pinmux_pkg::PUD_RESET[p]));
            apb(1'b1, a + 32'hc, 32'hffff_ffff);
            apb(1'b0, a + 32'hc, 32'h0);
            chk("rsv", rd | 32'(err), 32'h0);
            d = $random(seed);
            apb(1'b1, a + 32'h8, d);
            apb(1'b1, a, d);
            apb(1'b0, a, 32'h0);
            chk("sel rb", rd, d & gpio_pinmux_pkg::SEL_MASK[p]);
            apb(1'b1, a, 32'h5555_5555);
            apb(1'b1, a + 32'h4, d);
            @(negedge core_clk);
            chk("out", {pads[p].oe, pads[p].out}, {m, d[15:0] & m});
            chk("pullup", 32'(pads[p].pullup_en), 32'(~d[15:0] & m));
            repeat (2) @(posedge core_clk);
            apb(1'b0, a + 32'h4, 32'h0);
            chk("out rb", rd, 32'(d[15:0] & m));
            apb(1'b1, a, (p == 0 || p == 3) ? 32'hffff_ffff : 32'h0);
            rnd();
            chk("in oe", 32'(pads[p].oe), 32'h0);
            apb(1'b0, a + 32'h4, 32'h0);
            chk("in rb", rd, 32'(drv[p] & m));
        end
        apb(1'b0, 32'h5600_0050, 32'h0);
        chk("unmapped", 32'(err), 32'h1);
        apb(1'b1, BASE, 32'h002a_aaaa);
        apb(1'b1, BASE + 32'h10, 32'haaaa_aaaa);
        apb(1'b1, BASE + 32'h20, 32'haaaa_aaaa);
        rnd();
        chk("b oe", 32'(pads[0].oe), 32'h0000_02af);
        chk("b out", 32'({pads[0].out[9], pads[0].out[7], pads[0].out[5],
            pads[0].out[3:0]}),
            32'({g[36], g[37], g[38], g[3:0]}));
        chk("b in", 32'(q[3:0]), 32'({drv[0][4], drv[0][6], drv[0][8],
            drv[0][10]}));
        chk("c alt", {pads[1].oe, pads[1].out}, {16'hffff, g[11:4], g[35:28]});
        chk("d alt", {pads[2].oe, pads[2].out}, {16'hffff, g[27:12]});
        apb(1'b1, BASE + 32'h10, 32'hffff_ffff);
        apb(1'b1, BASE + 32'h20, 32'hffff_ffff);
        rnd();
        chk("audio", 32'({pads[1].oe[4], q[4]}), 32'({1'b0, drv[1][4]}));
        chk("spi oe", 32'(pads[2].oe), 32'({g[43], g[41], g[39]}) << 8);
        e = lvl(16'({g[43], g[41], g[39]}), 16'({g[44], g[42], g[40]}),
                16'(drv[2][10:8]));
        chk("spi in", 32'({q[5], q[6], q[7], q[8], q[9]}),
            32'({drv[2][15:14], e[2:0]}));
        wrap_up();
    end
endmodule : gpio_ports_b_to_e_pinmux_tb
`default_nettype wire
